// *** hdl/pmcm_pkg.sv ***
// package: command codes, reset values and carrier types of the command map
package pmcm_pkg;
   localparam int          NUM_CH        = 4;
   // command codes
   localparam logic [7:0]  CMD_PAGE      = 8'h00;
   localparam logic [7:0]  CMD_OPERATION = 8'h01;
   localparam logic [7:0]  CMD_ONOFF_CFG = 8'h02;
   localparam logic [7:0]  CMD_CLR_FAULT = 8'h03;
   localparam logic [7:0]  CMD_WR_PROT   = 8'h10;
   localparam logic [7:0]  CMD_ALT_CMD   = 8'hc8;
   localparam logic [7:0]  CMD_ALT0_DATA = 8'hc9;
   localparam logic [7:0]  CMD_ALT1_DATA = 8'hca;
   localparam logic [7:0]  CMD_GP_MASK   = 8'he4;
   localparam logic [7:0]  CMD_BASE_ADDR = 8'he6;
   localparam logic [7:0]  CMD_FAULT_LOG = 8'hee;
   localparam logic [7:0]  CMD_COMMON    = 8'hef;
   localparam logic [7:0]  CMD_GAIN_TC   = 8'hf6;
   localparam logic [7:0]  CMD_RETRY     = 8'hf7;
   localparam logic [7:0]  CMD_TEMP_GAIN = 8'hf8;
   localparam logic [7:0]  CMD_TEMP_OFS  = 8'hf9;
   localparam logic [7:0]  CMD_SENSE_V   = 8'hfa;
   localparam logic [7:0]  CMD_VOUT_MIN  = 8'hfb;
   localparam logic [7:0]  CMD_VIN_MIN   = 8'hfc;
   localparam logic [7:0]  CMD_TEMP_MIN  = 8'hfd;
   // page values
   localparam logic [7:0]  PAGE_LAST     = 8'h03;
   localparam logic [7:0]  PAGE_GLOBAL   = 8'hff;
   // reset values
   localparam logic [7:0]  RST_PAGE      = 8'h00;
   localparam logic [7:0]  RST_WR_PROT   = 8'h00;
   localparam logic [3:0]  RST_GP_MASK   = 4'hf;
   localparam logic [6:0]  RST_BASE_ADDR = 7'h5c;
   localparam logic [7:0]  RST_RETRY     = 8'h07;
   localparam logic [15:0] RST_GAIN_TC   = 16'h0000;
   localparam logic [15:0] RST_TEMP_GAIN = 16'h4000;
   localparam logic [15:0] RST_TEMP_OFS  = 16'h8000;
   localparam logic [15:0] RST_ALT       = 16'h0000;
   // trackers start at the largest value of their format
   localparam logic [15:0] RST_L16_MIN   = 16'hffff;
   localparam logic [15:0] RST_L11_MIN   = 16'h7bff;
   // field positions of the linear formats
   localparam int          L11_EXP_MSB   = 15;
   localparam int          L11_EXP_LSB   = 11;
   localparam int          L11_MAN_MSB   = 10;
   localparam int          L16_EXPONENT  = -13;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [15:0] data;
   } pmcm_req_t;

   typedef struct packed {
      logic [7:0]             page;
      logic [7:0]             wr_prot;
      logic [15:0]            alt_cmd;
      logic [15:0]            alt0;
      logic [15:0]            alt1;
      logic [3:0]             gp_mask;
      logic [6:0]             base_addr;
      logic [7:0]             retry;
      logic [3:0][15:0]       gain_tc;
      logic [3:0][15:0]       temp_gain;
      logic [3:0][15:0]       temp_ofs;
      logic [3:0][15:0]       vout_min;
      logic [15:0]            vin_min;
      logic [3:0][15:0]       temp_min;
      logic [15:0]            rdata;
      logic                   rvalid;
      logic                   cml;
      logic [3:0]             chan_wr;
      logic [7:0]             chan_code;
      logic [15:0]            chan_data;
      logic                   log_pop;
   } pmcm_state_t;
endpackage

// *** hdl/pmcm_command_map.sv ***
// command map: page routing, global page broadcast, configuration words, min trackers
`timescale 1ns/1ns
// Summary of operation
// - page 0x00..0x03 routes paged commands to channel 0..3; others reserved.
// - page 0xFF broadcasts a global-capable write to channels enabled in the mask.
// - only clear faults, operation and on/off config accept global paging.
// - paged read at page 0xFF returns undefined data and flags comm fault.
// - non-global paged write at page 0xFF is discarded and flags comm fault.
// - page byte at 0x00, read/write, not paged, resets to 0x00.
// - write-protect byte at 0x10, read/write, not paged, resets to 0x00.
// - bus address base byte at 0xE6, read/write, default 0x5C.
// - global page mask byte at 0xE4, read/write, default 0x0F.
// - alternate host words at 0xC8, 0xC9, 0xCA, read/write.
// - eleven-bit linear: bits 15:11 signed exponent, 10:0 signed mantissa.
// - sixteen-bit linear output voltage: unsigned mantissa, fixed exponent -13.
// - 0xEE read returns fault log bytes one after another.
// - 0xEF read-only byte returns family common status bits.
// - 0xF6 paged word, current gain tempco, default 0x0000.
// - 0xF7 non-paged retry count byte, default 0x07.
// - 0xF8 paged word, inverse diode non-ideality, default 0x4000.
// - 0xF9 paged word, external temperature offset, default 0x8000.
// - 0xFA paged read-only word, current-sense voltage magnitude.
// - minimum trackers: vout 0xFB paged, vin 0xFC, temperature 0xFD paged.
// - mask bits 3:0 enable channels for global access; bits 7:4 read zero.
module pmcm_command_map (
   // clock and reset
   input  wire logic                   ref_clk_i,
   input  wire logic                   reset_n_i,
   // decoded host command
   input  wire pmcm_pkg::pmcm_req_t    req_i,
   output logic [15:0]                 rdata_o,
   output logic                        rvalid_o,
   output logic                        cml_fault_o,
   // forwarded channel commands
   output logic [3:0]                  chan_wr_o,
   output logic [7:0]                  chan_code_o,
   output logic [15:0]                 chan_data_o,
   // fault log source
   input  wire logic [7:0]             log_byte_i,
   output logic                        log_pop_o,
   // status and measurements
   input  wire logic [7:0]             common_status_i,
   input  wire logic [3:0][15:0]       sense_v_i,
   input  wire logic [3:0]             meas_valid_i,
   input  wire logic [3:0][15:0]       vout_meas_i,
   input  wire logic [3:0][15:0]       temp_meas_i,
   input  wire logic                   vin_valid_i,
   input  wire logic [15:0]            vin_meas_i,
   // configuration out
   output logic [7:0]                  wr_prot_o,
   output logic [6:0]                  base_addr_o,
   output logic [7:0]                  retry_o
);
   pmcm_pkg::pmcm_state_t s;
   pmcm_pkg::pmcm_state_t next_s;

   // ********************************
   // command classes and number formats
   // ********************************

   function automatic logic is_global(input logic [7:0] c);
      return c == pmcm_pkg::CMD_OPERATION || c == pmcm_pkg::CMD_ONOFF_CFG ||
             c == pmcm_pkg::CMD_CLR_FAULT;
   endfunction

   function automatic logic is_paged(input logic [7:0] c);
      unique case (c)
         pmcm_pkg::CMD_OPERATION,
         pmcm_pkg::CMD_ONOFF_CFG,
         pmcm_pkg::CMD_CLR_FAULT,
         pmcm_pkg::CMD_GAIN_TC,
         pmcm_pkg::CMD_TEMP_GAIN,
         pmcm_pkg::CMD_TEMP_OFS,
         pmcm_pkg::CMD_SENSE_V,
         pmcm_pkg::CMD_VOUT_MIN,
         pmcm_pkg::CMD_TEMP_MIN: return 1'b1;
         default:                return 1'b0;
      endcase
   endfunction

   // eleven-bit linear to a fixed point value scaled by 2^16, so all exponents compare
   function automatic logic signed [47:0] l11_val(input logic [15:0] w);
      logic signed [47:0] m;
      logic [4:0]         sh;
      m  = 48'(signed'(w[pmcm_pkg::L11_MAN_MSB:0]));
      sh = {~w[pmcm_pkg::L11_EXP_MSB], w[pmcm_pkg::L11_EXP_MSB-1:pmcm_pkg::L11_EXP_LSB]};
      return m <<< sh;
   endfunction

   // ********************************
   // page decode
   // ********************************

   logic [1:0] ch;
   logic       page_ok;
   logic       page_glob;

   assign ch        = s.page[1:0];
   assign page_ok   = s.page <= pmcm_pkg::PAGE_LAST;
   assign page_glob = s.page == pmcm_pkg::PAGE_GLOBAL;

   // ********************************
   // next state
   // ********************************

   always_comb begin
      next_s         = s;
      next_s.rvalid  = 1'b0;
      next_s.cml     = 1'b0;
      next_s.chan_wr = 4'h0;
      next_s.log_pop = 1'b0;
      if (req_i.valid) begin
         if (is_paged(req_i.code) && !page_ok) begin
            if (req_i.write && page_glob && is_global(req_i.code)) begin
               next_s.chan_wr   = s.gp_mask;
               next_s.chan_code = req_i.code;
               next_s.chan_data = req_i.data;
            end else begin
               // reads answer zero; the value carries no meaning
               next_s.cml    = 1'b1;
               next_s.rvalid = !req_i.write;
               next_s.rdata  = 16'h0000;
            end
         end else if (req_i.write) begin
            unique case (req_i.code)
               pmcm_pkg::CMD_PAGE:      next_s.page = req_i.data[7:0];
               pmcm_pkg::CMD_WR_PROT:   next_s.wr_prot = req_i.data[7:0];
               pmcm_pkg::CMD_ALT_CMD:   next_s.alt_cmd = req_i.data;
               pmcm_pkg::CMD_ALT0_DATA: next_s.alt0 = req_i.data;
               pmcm_pkg::CMD_ALT1_DATA: next_s.alt1 = req_i.data;
               pmcm_pkg::CMD_GP_MASK:   next_s.gp_mask = req_i.data[3:0];
               pmcm_pkg::CMD_BASE_ADDR: next_s.base_addr = req_i.data[6:0];
               pmcm_pkg::CMD_RETRY:     next_s.retry = req_i.data[7:0];
               pmcm_pkg::CMD_GAIN_TC:   next_s.gain_tc[ch] = req_i.data;
               pmcm_pkg::CMD_TEMP_GAIN: next_s.temp_gain[ch] = req_i.data;
               pmcm_pkg::CMD_TEMP_OFS:  next_s.temp_ofs[ch] = req_i.data;
               pmcm_pkg::CMD_OPERATION,
               pmcm_pkg::CMD_ONOFF_CFG,
               pmcm_pkg::CMD_CLR_FAULT: begin
                  next_s.chan_wr   = 4'(4'h1 << ch);
                  next_s.chan_code = req_i.code;
                  next_s.chan_data = req_i.data;
               end
               // read-only and unknown codes ignore writes
               default: next_s.rvalid = 1'b0;
            endcase
         end else begin
            next_s.rvalid = 1'b1;
            unique case (req_i.code)
               pmcm_pkg::CMD_PAGE:      next_s.rdata = {8'h00, s.page};
               pmcm_pkg::CMD_WR_PROT:   next_s.rdata = {8'h00, s.wr_prot};
               pmcm_pkg::CMD_ALT_CMD:   next_s.rdata = s.alt_cmd;
               pmcm_pkg::CMD_ALT0_DATA: next_s.rdata = s.alt0;
               pmcm_pkg::CMD_ALT1_DATA: next_s.rdata = s.alt1;
               pmcm_pkg::CMD_GP_MASK:   next_s.rdata = {12'h000, s.gp_mask};
               pmcm_pkg::CMD_BASE_ADDR: next_s.rdata = {9'h000, s.base_addr};
               pmcm_pkg::CMD_RETRY:     next_s.rdata = {8'h00, s.retry};
               pmcm_pkg::CMD_FAULT_LOG: begin
                  next_s.rdata   = {8'h00, log_byte_i};
                  next_s.log_pop = 1'b1;
               end
               pmcm_pkg::CMD_COMMON:    next_s.rdata = {8'h00, common_status_i};
               pmcm_pkg::CMD_GAIN_TC:   next_s.rdata = s.gain_tc[ch];
               pmcm_pkg::CMD_TEMP_GAIN: next_s.rdata = s.temp_gain[ch];
               pmcm_pkg::CMD_TEMP_OFS:  next_s.rdata = s.temp_ofs[ch];
               pmcm_pkg::CMD_SENSE_V:   next_s.rdata = sense_v_i[ch];
               pmcm_pkg::CMD_VOUT_MIN:  next_s.rdata = s.vout_min[ch];
               pmcm_pkg::CMD_VIN_MIN:   next_s.rdata = s.vin_min;
               pmcm_pkg::CMD_TEMP_MIN:  next_s.rdata = s.temp_min[ch];
               default:                 next_s.rdata = 16'h0000;
            endcase
         end
      end
      // trackers run beside host traffic; reads see the value of the previous cycle
      for (int i = 0; i < pmcm_pkg::NUM_CH; i++) begin
         if (meas_valid_i[i]) begin
            if (vout_meas_i[i] < s.vout_min[i]) begin
               next_s.vout_min[i] = vout_meas_i[i];
            end
            if (l11_val(temp_meas_i[i]) < l11_val(s.temp_min[i])) begin
               next_s.temp_min[i] = temp_meas_i[i];
            end
         end
      end
      if (vin_valid_i && l11_val(vin_meas_i) < l11_val(s.vin_min)) begin
         next_s.vin_min = vin_meas_i;
      end
   end

   // ********************************
   // registers
   // ********************************

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         s           <= '0;
         s.page      <= pmcm_pkg::RST_PAGE;
         s.wr_prot   <= pmcm_pkg::RST_WR_PROT;
         s.alt_cmd   <= pmcm_pkg::RST_ALT;
         s.alt0      <= pmcm_pkg::RST_ALT;
         s.alt1      <= pmcm_pkg::RST_ALT;
         s.gp_mask   <= pmcm_pkg::RST_GP_MASK;
         s.base_addr <= pmcm_pkg::RST_BASE_ADDR;
         s.retry     <= pmcm_pkg::RST_RETRY;
         s.gain_tc   <= {4{pmcm_pkg::RST_GAIN_TC}};
         s.temp_gain <= {4{pmcm_pkg::RST_TEMP_GAIN}};
         s.temp_ofs  <= {4{pmcm_pkg::RST_TEMP_OFS}};
         s.vout_min  <= {4{pmcm_pkg::RST_L16_MIN}};
         s.vin_min   <= pmcm_pkg::RST_L11_MIN;
         s.temp_min  <= {4{pmcm_pkg::RST_L11_MIN}};
      end else begin
         s <= next_s;
      end
   end

   // ********************************
   // outputs
   // ********************************

   assign rdata_o     = s.rdata;
   assign rvalid_o    = s.rvalid;
   assign cml_fault_o = s.cml;
   assign chan_wr_o   = s.chan_wr;
   assign chan_code_o = s.chan_code;
   assign chan_data_o = s.chan_data;
   assign log_pop_o   = s.log_pop;
   assign wr_prot_o   = s.wr_prot;
   assign base_addr_o = s.base_addr;
   assign retry_o     = s.retry;

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   reset_values_a: assert property ($rose(reset_n_i) |-> s.page == 8'h00 && s.retry == 8'h07 &&
      s.gp_mask == 4'hf && s.base_addr == 7'h5c && s.temp_gain[0] == 16'h4000)
      else $error("reset values wrong");
   page_write_a: assert property (req_i.valid && req_i.write && req_i.code == 8'h00 |=>
      s.page == $past(req_i.data[7:0]))
      else $error("page write lost");
   global_bcast_a: assert property (req_i.valid && req_i.write && page_glob && is_global(req_i.code)
      |=> chan_wr_o == $past(s.gp_mask) && !cml_fault_o)
      else $error("global broadcast wrong");
   global_read_a: assert property (req_i.valid && !req_i.write && page_glob && is_paged(req_i.code)
      |=> cml_fault_o && rvalid_o)
      else $error("global read not flagged");
   global_discard_a: assert property (req_i.valid && req_i.write && page_glob &&
      req_i.code == 8'hf6 |=> cml_fault_o && s.gain_tc == $past(s.gain_tc))
      else $error("global write not discarded");
   reserved_page_a: assert property (req_i.valid && req_i.write && !page_ok && !page_glob &&
      req_i.code == 8'hf8 |=> cml_fault_o && s.temp_gain == $past(s.temp_gain))
      else $error("reserved page write taken");
   mask_upper_a: assert property (rvalid_o && $past(req_i.code) == 8'he4 && $past(page_ok)
      |-> rdata_o[15:4] == 12'h000)
      else $error("mask upper bits set");
   log_pop_a: assert property (req_i.valid && !req_i.write && req_i.code == 8'hee
      |=> log_pop_o && rdata_o == {8'h00, $past(log_byte_i)})
      else $error("fault log read wrong");
   routed_write_a: assert property (req_i.valid && req_i.write && page_ok && req_i.code == 8'h01
      |=> chan_wr_o == 4'(4'h1 << $past(ch)))
      else $error("paged routing wrong");
   vin_track_a: assert property (vin_valid_i && l11_val(vin_meas_i) < l11_val(s.vin_min)
      |=> s.vin_min == $past(vin_meas_i))
      else $error("vin minimum not tracked");

   // every read is answered exactly one cycle later, writes never are
   read_answer_a: assert property (req_i.valid && !req_i.write
      |=> rvalid_o)
      else $error("read not answered");

   write_silent_a: assert property (req_i.valid && req_i.write
      |=> !rvalid_o)
      else $error("write answered as read");

   idle_quiet_a: assert property (!req_i.valid
      |=> !rvalid_o && !cml_fault_o && chan_wr_o == 4'h0 && !log_pop_o)
      else $error("pulse without request");

   // register writes land one cycle after the request
   wrprot_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_WR_PROT
      |=> wr_prot_o == $past(req_i.data[7:0]))
      else $error("write protect write lost");

   mask_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_GP_MASK
      |=> s.gp_mask == $past(req_i.data[3:0]))
      else $error("mask write lost");

   base_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_BASE_ADDR
      |=> base_addr_o == $past(req_i.data[6:0]))
      else $error("base address write lost");

   retry_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_RETRY
      |=> retry_o == $past(req_i.data[7:0]) && !cml_fault_o)
      else $error("retry write lost");

   alt_cmd_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_ALT_CMD
      |=> s.alt_cmd == $past(req_i.data))
      else $error("alt command write lost");

   alt0_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_ALT0_DATA
      |=> s.alt0 == $past(req_i.data))
      else $error("alt host0 write lost");

   alt1_write_a: assert property (req_i.valid && req_i.write && req_i.code == pmcm_pkg::CMD_ALT1_DATA
      |=> s.alt1 == $past(req_i.data))
      else $error("alt host1 write lost");

   // paged words land in the selected channel; forwarded commands keep their code and data
   gain_tc_write_a: assert property (req_i.valid && req_i.write && page_ok && req_i.code == pmcm_pkg::CMD_GAIN_TC
      |=> s.gain_tc[$past(ch)] == $past(req_i.data))
      else $error("gain tempco write lost");

   temp_gain_write_a: assert property (req_i.valid && req_i.write && page_ok &&
      req_i.code == pmcm_pkg::CMD_TEMP_GAIN |=> s.temp_gain[$past(ch)] == $past(req_i.data))
      else $error("diode gain write lost");

   temp_ofs_write_a: assert property (req_i.valid && req_i.write && page_ok &&
      req_i.code == pmcm_pkg::CMD_TEMP_OFS |=> s.temp_ofs[$past(ch)] == $past(req_i.data))
      else $error("temperature offset write lost");

   routed_data_a: assert property (req_i.valid && req_i.write && page_ok && is_global(req_i.code)
      |=> chan_code_o == $past(req_i.code) && chan_data_o == $past(req_i.data))
      else $error("forwarded command wrong");

   routed_no_fault_a: assert property (req_i.valid && page_ok
      |=> !cml_fault_o)
      else $error("fault at valid page");

   // read data
   page_read_a: assert property (req_i.valid && !req_i.write && req_i.code == pmcm_pkg::CMD_PAGE
      |=> rdata_o == {8'h00, $past(s.page)})
      else $error("page read wrong");

   common_read_a: assert property (req_i.valid && !req_i.write && req_i.code == pmcm_pkg::CMD_COMMON
      |=> rdata_o == {8'h00, $past(common_status_i)} && !cml_fault_o)
      else $error("common status read wrong");

   sense_read_a: assert property (req_i.valid && !req_i.write && page_ok && req_i.code == pmcm_pkg::CMD_SENSE_V
      |=> rdata_o == $past(sense_v_i[ch]))
      else $error("sense voltage read wrong");

   vout_min_read_a: assert property (req_i.valid && !req_i.write && page_ok &&
      req_i.code == pmcm_pkg::CMD_VOUT_MIN |=> rdata_o == $past(s.vout_min[ch]))
      else $error("vout minimum read wrong");

   vin_min_read_a: assert property (req_i.valid && !req_i.write && req_i.code == pmcm_pkg::CMD_VIN_MIN
      |=> rdata_o == $past(s.vin_min))
      else $error("vin minimum read wrong");

   glob_read_zero_a: assert property (req_i.valid && !req_i.write && page_glob && is_paged(req_i.code)
      |=> rdata_o == 16'h0000)
      else $error("global read data not zero");

   reserved_read_a: assert property (req_i.valid && !req_i.write && !page_ok && !page_glob &&
      is_paged(req_i.code) |=> cml_fault_o && rdata_o == 16'h0000)
      else $error("reserved page read not flagged");

   // trackers
   vout_track_a: assert property (meas_valid_i[1] && vout_meas_i[1] < s.vout_min[1]
      |=> s.vout_min[1] == $past(vout_meas_i[1]))
      else $error("vout minimum not tracked");

   vout_keep_a: assert property (meas_valid_i[1] && vout_meas_i[1] >= s.vout_min[1]
      |=> $stable(s.vout_min[1]))
      else $error("vout minimum raised");

   temp_track_a: assert property (meas_valid_i[1] && l11_val(temp_meas_i[1]) < l11_val(s.temp_min[1])
      |=> s.temp_min[1] == $past(temp_meas_i[1]))
      else $error("temperature minimum not tracked");
endmodule

// *** verification/pmcm_host_model.sv ***
// host model: issues one decoded command at a time and samples the answer pulses
`timescale 1ns/1ns
module pmcm_host_model (
   // clock
   input  wire logic             ref_clk_i,
   // command port
   output pmcm_pkg::pmcm_req_t   req_o,
   input  wire logic [15:0]      rdata_i,
   input  wire logic             rvalid_i,
   input  wire logic             cml_fault_i,
   input  wire logic [3:0]       chan_wr_i,
   input  wire logic             log_pop_i
);
   initial req_o = '0;
   // released code and data show the inverse so a stale value is never mistaken for a request
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                       output logic [15:0] rd, output logic [7:0] flags);
      @(posedge ref_clk_i);
      req_o <= '{valid: 1'b1, write: wr, code: code, data: data};
      @(posedge ref_clk_i);
      req_o <= '{valid: 1'b0, write: 1'b0, code: ~code, data: ~data};
      #1;
      rd = rdata_i;
      flags = {1'b0, rvalid_i, cml_fault_i, log_pop_i, chan_wr_i};
   endtask
endmodule

// *** verification/pmcm_command_map_tb.sv ***
// testbench of the command map
`timescale 1ns/1ns
module pmcm_command_map_tb;
   logic                ref_clk_i = 1'b0;
   logic                reset_n_i = 1'b0;
   pmcm_pkg::pmcm_req_t req;
   logic [15:0]         rdata_o;
   logic                rvalid_o, cml_fault_o, log_pop_o;
   logic [3:0]          chan_wr_o;
   logic [7:0]          chan_code_o, wr_prot_o, retry_o;
   logic [15:0]         chan_data_o;
   logic [6:0]          base_addr_o;
   logic [7:0]          log_byte_i = 8'h00;
   logic [7:0]          common_status_i = 8'h00;
   logic [3:0][15:0]    sense_v_i = {16'h0f03, 16'h0f02, 16'h0f01, 16'h0f00};
   logic [3:0]          meas_valid_i = 4'h0;
   logic [3:0][15:0]    vout_meas_i = '0;
   logic [3:0][15:0]    temp_meas_i = '0;
   logic                vin_valid_i = 1'b0;
   logic [15:0]         vin_meas_i = 16'h0000;
   logic [15:0]         rd_v;
   logic [7:0]          fl;
   int                  fail_count = 0;
   int                  cmp_count = 0;

   initial forever #20 ref_clk_i = ~ref_clk_i;

   pmcm_command_map i_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .req_i(req), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .cml_fault_o(cml_fault_o), .chan_wr_o(chan_wr_o), .chan_code_o(chan_code_o),
      .chan_data_o(chan_data_o), .log_byte_i(log_byte_i), .log_pop_o(log_pop_o),
      .common_status_i(common_status_i), .sense_v_i(sense_v_i), .meas_valid_i(meas_valid_i),
      .vout_meas_i(vout_meas_i), .temp_meas_i(temp_meas_i), .vin_valid_i(vin_valid_i),
      .vin_meas_i(vin_meas_i), .wr_prot_o(wr_prot_o), .base_addr_o(base_addr_o), .retry_o(retry_o));

   pmcm_host_model h (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
      .cml_fault_i(cml_fault_o), .chan_wr_i(chan_wr_o), .log_pop_i(log_pop_o));

   // ***************
   // helpers
   // ***************
   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      h.xfer(1'b1, c, d, rd_v, fl);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      h.xfer(1'b0, c, 16'h0000, rd_v, fl);
      chk("rdata", e, rd_v);
      chk("rvalid", 16'h0001, {15'h0, fl[6]});
   endtask
   task automatic strobe(input int ch, input logic [15:0] vo, input logic [15:0] te);
      @(posedge ref_clk_i);
      meas_valid_i <= 4'(4'h1 << ch);
      vout_meas_i[ch] <= vo;
      temp_meas_i[ch] <= te;
      @(posedge ref_clk_i);
      meas_valid_i <= 4'h0;
   endtask

   // ***************
   // scenarios
   // ***************
   task automatic t_reset();
      rd(8'h00, 16'h0000);
      rd(8'h10, 16'h0000);
      rd(8'he4, 16'h000f);
      rd(8'he6, 16'h005c);
      rd(8'hf7, 16'h0007);
      rd(8'hf6, 16'h0000);
      rd(8'hf8, 16'h4000);
      rd(8'hf9, 16'h8000);
      chk("retry_o", 16'h0007, {8'h0, retry_o});
   endtask
   task automatic t_regs();
      wr(8'h10, 16'h0040);
      rd(8'h10, 16'h0040);
      chk("wr_prot_o", 16'h0040, {8'h0, wr_prot_o});
      wr(8'he4, 16'h00f5);
      rd(8'he4, 16'h0005);
      wr(8'he6, 16'h00ff);
      rd(8'he6, 16'h007f);
      chk("base_addr_o", 16'h007f, {9'h0, base_addr_o});
      for (int i = 0; i < 3; i++) wr(8'hc8 + 8'(i), 16'h1234 + 16'(i));
      for (int i = 0; i < 3; i++) rd(8'hc8 + 8'(i), 16'h1234 + 16'(i));
   endtask
   task automatic t_pages();
      for (int p = 0; p < 4; p++) begin
         wr(8'h00, 16'(p));
         wr(8'hf6, 16'ha000 + 16'(p));
         wr(8'hf8, 16'h5000 + 16'(p));
      end
      for (int p = 0; p < 4; p++) begin
         wr(8'h00, 16'(p));
         rd(8'h00, 16'(p));
         rd(8'hf6, 16'ha000 + 16'(p));
         rd(8'hfa, 16'h0f00 + 16'(p));
      end
   endtask
   task automatic t_global();
      wr(8'he4, 16'h0005);
      wr(8'h00, 16'h00ff);
      for (int c = 1; c < 4; c++) begin
         wr(8'(c), 16'h0080 + 16'(c));
         chk("chan_wr", 16'h0005, {12'h0, fl[3:0]});
         chk("cml", 16'h0000, {15'h0, fl[5]});
         chk("chan_code", 16'(c), {8'h0, chan_code_o});
         chk("chan_data", 16'h0080 + 16'(c), chan_data_o);
      end
      wr(8'hf8, 16'h1111);
      chk("cml", 16'h0001, {15'h0, fl[5]});
      chk("chan_wr", 16'h0000, {12'h0, fl[3:0]});
      h.xfer(1'b0, 8'hf6, 16'h0000, rd_v, fl);
      chk("cml", 16'h0001, {15'h0, fl[5]});
      wr(8'hf7, 16'h0009);
      rd(8'hf7, 16'h0009);
      wr(8'h00, 16'h0007);
      wr(8'hf8, 16'h2222);
      chk("cml", 16'h0001, {15'h0, fl[5]});
      wr(8'h00, 16'h0002);
      rd(8'hf8, 16'h5002);
   endtask
   task automatic t_log();
      log_byte_i <= 8'h3c;
      common_status_i <= 8'h81;
      rd(8'hee, 16'h003c);
      chk("log_pop", 16'h0001, {15'h0, fl[4]});
      log_byte_i <= 8'hc3;
      rd(8'hee, 16'h00c3);
      wr(8'hef, 16'h0000);
      rd(8'hef, 16'h0081);
   endtask
   task automatic t_track();
      strobe(1, 16'h9800, 16'hd280);
      strobe(1, 16'ha000, 16'h0005);
      strobe(1, 16'h9000, 16'h07ff);
      @(posedge ref_clk_i);
      vin_valid_i <= 1'b1;
      vin_meas_i <= 16'hd280;
      @(posedge ref_clk_i);
      vin_meas_i <= 16'h0014;
      @(posedge ref_clk_i);
      vin_valid_i <= 1'b0;
      wr(8'h00, 16'h0001);
      rd(8'hfb, 16'h9000);
      rd(8'hfd, 16'h07ff);
      rd(8'hfc, 16'hd280);
      wr(8'h00, 16'h0000);
      rd(8'hfb, 16'hffff);
   endtask

   task automatic conclude();
      if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (3000) @(posedge ref_clk_i);
      fail_count++;
      conclude();
   end

   initial begin
      repeat (12) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_regs();
      t_pages();
      t_global();
      t_log();
      t_track();
      conclude();
   end
endmodule
